/* rtl/mfd_pkg.sv */
// Package of the motor fault diagnostics block: register map, field
// positions, reset values, timing counts and threshold codes.
// Assumes a 100 MHz system clock and a classic Wishbone register bus.
package mfd_pkg;

   // Register byte offsets.
   localparam logic [7:0] REG_CONF   = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_IRQST  = 8'h08;
   localparam logic [7:0] REG_IRQMSK = 8'h0c;

   // Configuration field positions.
   localparam int CONF_DRV_EN   = 0;
   localparam int CONF_TSEL_LO  = 1;
   localparam int CONF_STALL_EN = 3;
   localparam int CONF_MARK_STP = 4;
   localparam int CONF_PW143    = 5;
   localparam int CONF_USE_OTP  = 6;
   localparam int CONF_W        = 7;
   localparam logic [6:0] CONF_RESET = 7'h00;

   // Status word bit positions.
   localparam int ST_OT    = 0;
   localparam int ST_OTPW  = 1;
   localparam int ST_BRIDGE_A_GROUND_SHORT_FLAG  = 2;
   localparam int ST_BRIDGE_B_GROUND_SHORT_FLAG  = 3;
   localparam int ST_BRIDGE_A_SUPPLY_SHORT_FLAG = 4;
   localparam int ST_BRIDGE_B_SUPPLY_SHORT_FLAG = 5;
   localparam int ST_OLA   = 6;
   localparam int ST_OLB   = 7;
   localparam int ST_UV    = 8;
   localparam int ST_STALL = 9;
   localparam int ST_W     = 10;

   // Interrupt events share the low status layout.
   localparam int IRQ_W = 10;
   localparam logic [9:0] IRQ_MASK_RESET = 10'h000;

   // Temperature threshold pair selection codes.
   localparam logic [1:0] TSEL_143 = 2'h0;
   localparam logic [1:0] TSEL_150 = 2'h1;
   localparam logic [1:0] TSEL_157 = 2'h2;

   // Thresholds in degrees Celsius.
   localparam logic [7:0] TEMP_120 = 8'h78;
   localparam logic [7:0] TEMP_143 = 8'h8f;
   localparam logic [7:0] TEMP_150 = 8'h96;
   localparam logic [7:0] TEMP_157 = 8'h9d;

   // Number of short detections before a bridge is switched off.
   localparam logic [1:0] SHORT_RETRIES = 2'h3;

   // Short detect qualification time and its cycle count.
   localparam int SYS_CLK_MHZ      = 100;
   localparam int SHORT_QUAL_NS    = 100;
   localparam int SHORT_QUAL_CYC   = (SHORT_QUAL_NS * SYS_CLK_MHZ + 999) / 1000;

   typedef enum logic [1:0] {
      BR_RUN   = 2'b00,
      BR_RETRY = 2'b01,
      BR_OFF   = 2'b10
   } mfd_bridge_state_type;

endpackage

/* rtl/mfd_short_guard.sv */
// One bridge short protection unit: qualifies short pulses, retries and
// latches the bridge off until the driver is disabled.
// Assumes short inputs are already synchronised to sys_clk.
`timescale 1ns/10ps
`default_nettype none
module mfd_short_guard
   import mfd_pkg::*;
(
   input  wire logic sys_clk,
   input  wire logic rst,
   input  wire logic drvEnable,
   input  wire logic groundShort,
   input  wire logic supplyShort,
   output logic      bridgeOff,
   output logic      groundFlag,
   output logic      supplyFlag
);
   import mfd_pkg::*;

   typedef struct packed {
      mfd_bridge_state_type state;
      logic [1:0]           tries;
      logic [7:0]           qual;
      logic                 gnd;
      logic                 sup;
   } mfd_guard_type;

   mfd_guard_type cur_ff;
   mfd_guard_type nxt_cur;
   logic          anyShort;

   assign anyShort = groundShort | supplyShort;

   always_comb begin
      nxt_cur = cur_ff;
      case (cur_ff.state)
         BR_RUN: begin
            if (drvEnable && anyShort) begin
               nxt_cur.qual = cur_ff.qual + 8'h01;
               if (cur_ff.qual >= 8'(SHORT_QUAL_CYC - 1)) begin
                  // A short lasting the qualification time counts once.
                  nxt_cur.qual  = 8'h00;
                  nxt_cur.tries = cur_ff.tries + 2'h1;
                  nxt_cur.state = BR_RETRY;
               end
            end else begin
               nxt_cur.qual = 8'h00;
            end
         end
         BR_RETRY: begin
            // The bridge is briefly released; a third hit confirms.
            if (cur_ff.tries >= SHORT_RETRIES) begin
               nxt_cur.state = BR_OFF;
               nxt_cur.gnd   = groundShort;
               nxt_cur.sup   = supplyShort | ~groundShort;
            end else if (!anyShort) begin
               nxt_cur.state = BR_RUN;
            end else begin
               nxt_cur.state = BR_RUN;
            end
         end
         BR_OFF: begin
            if (!drvEnable) begin
               nxt_cur.state = BR_RUN;
               nxt_cur.tries = 2'h0;
               nxt_cur.gnd   = 1'b0;
               nxt_cur.sup   = 1'b0;
            end
         end
         default: nxt_cur.state = BR_RUN;
      endcase
      if (!drvEnable && cur_ff.state != BR_OFF) begin
         nxt_cur.tries = 2'h0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         cur_ff <= '{BR_RUN, 2'h0, 8'h00, 1'b0, 1'b0};
      end else begin
         cur_ff <= nxt_cur;
      end
   end

   assign bridgeOff  = (cur_ff.state != BR_RUN);
   assign groundFlag = cur_ff.gnd;
   assign supplyFlag = cur_ff.sup;
endmodule
`default_nettype wire

/* rtl/mfd_fault_fault_output_pin.sv */
// Top of the motor fault diagnostics block: temperature protection, short
// guards for two bridges, open-load flags, fault and marker pins, and a
// Wishbone register slave with sticky interrupt status.
// Assumes analog comparators and stall detection give raw pin-level inputs.
//
// Chosen here: the register offsets and the Wishbone slave port.
`timescale 1ns/10ps
`default_nettype none
module mfd_fault_fault_output_pin
   import mfd_pkg::*;
(
   input  wire logic       sys_clk,
   input  wire logic       rst,
   // Wishbone slave.
   input  wire logic       wb_cyc_i,
   input  wire logic       wb_stb_i,
   input  wire logic       wb_we_i,
   input  wire logic [7:0] wb_adr_i,
   input  wire logic [3:0] wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]     wb_dat_o,
   output logic            wb_ack_o,
   output logic            irq,
   // Sensors and motion, asynchronous to sys_clk.
   input  wire logic [7:0] dieTemp,
   input  wire logic       shortGndA,
   input  wire logic       shortGndB,
   input  wire logic       shortSupA,
   input  wire logic       shortSupB,
   input  wire logic       underVoltage,
   input  wire logic       coilLowA,
   input  wire logic       coilLowB,
   input  wire logic       stallDetect,
   input  wire logic       stepDone,
   input  wire logic       stepAtZero,
   input  wire logic [1:0] otpTempSel,
   input  wire logic       otpPw143,
   // Outputs.
   output logic            bridgeAEnable,
   output logic            bridgeBEnable,
   output logic            faultOutputPin,
   output logic            markerPin
);
   import mfd_pkg::*;

   localparam int SYNC_W = 21;

   typedef struct packed {
      logic [SYNC_W-1:0] syncA;
      logic [SYNC_W-1:0] syncB;
      logic [CONF_W-1:0] conf;
      logic              ot;
      logic              otpw;
      logic              stepPrev;
      logic              marker;
      logic [IRQ_W-1:0]  irqSt;
      logic [IRQ_W-1:0]  irqMask;
      logic [ST_W-1:0]   statPrev;
      logic              ack;
      logic [31:0]       rdata;
   } mfd_top_type;

   mfd_top_type cur_ff;
   mfd_top_type nxt_cur;

   logic [SYNC_W-1:0] rawIn;
   logic [SYNC_W-1:0] syncIn;
   logic [7:0]        temp;
   logic              sGndA;
   logic              sGndB;
   logic              sSupA;
   logic              sSupB;
   logic              uv;
   logic              olA;
   logic              olB;
   logic              stall;
   logic              step;
   logic              atZero;
   logic [1:0]        sOtpSel;
   logic              sOtpPw;
   logic              offA;
   logic              offB;
   logic              gfA;
   logic              gfB;
   logic              sfA;
   logic              sfB;
   logic              drvEn;
   logic [1:0]        tsel;
   logic              pw143;
   logic [7:0]        shutLvl;
   logic [7:0]        warnLvl;
   logic [ST_W-1:0]   status;
   logic              wbReq;

   assign rawIn = {dieTemp, shortGndA, shortGndB, shortSupA, shortSupB,
                   underVoltage, coilLowA, coilLowB, stallDetect, stepDone,
                   stepAtZero, otpTempSel, otpPw143};
   // Two flops per input; only the second stage feeds any logic.
   assign syncIn = cur_ff.syncB;
   assign temp    = syncIn[20:13];
   assign sGndA   = syncIn[12];
   assign sGndB   = syncIn[11];
   assign sSupA   = syncIn[10];
   assign sSupB   = syncIn[9];
   assign uv      = syncIn[8];
   assign olA     = syncIn[7];
   assign olB     = syncIn[6];
   assign stall   = syncIn[5];
   assign step    = syncIn[4];
   assign atZero  = syncIn[3];
   assign sOtpSel = syncIn[2:1];
   assign sOtpPw  = syncIn[0];

   assign drvEn = cur_ff.conf[CONF_DRV_EN];

   // Straps pass the synchroniser too, as a strap may settle after reset.
   always_comb begin
      if (cur_ff.conf[CONF_USE_OTP]) begin
         // The 157 C pair is not reachable from the one-time setting.
         tsel  = (sOtpSel == TSEL_150) ? TSEL_150 : TSEL_143;
         pw143 = sOtpPw;
      end else begin
         tsel  = cur_ff.conf[CONF_TSEL_LO +: 2];
         pw143 = cur_ff.conf[CONF_PW143];
      end
      case (tsel)
         TSEL_150: begin
            shutLvl = TEMP_150;
            warnLvl = pw143 ? TEMP_143 : TEMP_120;
         end
         TSEL_157: begin
            shutLvl = TEMP_157;
            warnLvl = TEMP_143;
         end
         default: begin
            shutLvl = TEMP_143;
            warnLvl = TEMP_120;
         end
      endcase
   end

   mfd_short_guard u_guard_a (
      .sys_clk     (sys_clk),
      .rst         (rst),
      .drvEnable   (drvEn),
      .groundShort (sGndA),
      .supplyShort (sSupA),
      .bridgeOff   (offA),
      .groundFlag  (gfA),
      .supplyFlag  (sfA)
   );

   mfd_short_guard u_guard_b (
      .sys_clk     (sys_clk),
      .rst         (rst),
      .drvEnable   (drvEn),
      .groundShort (sGndB),
      .supplyShort (sSupB),
      .bridgeOff   (offB),
      .groundFlag  (gfB),
      .supplyFlag  (sfB)
   );

   always_comb begin
      status           = '0;
      status[ST_OT]    = cur_ff.ot;
      status[ST_OTPW]  = cur_ff.otpw;
      status[ST_BRIDGE_A_GROUND_SHORT_FLAG]  = gfA;
      status[ST_BRIDGE_B_GROUND_SHORT_FLAG]  = gfB;
      status[ST_BRIDGE_A_SUPPLY_SHORT_FLAG] = sfA;
      status[ST_BRIDGE_B_SUPPLY_SHORT_FLAG] = sfB;
      status[ST_OLA]   = olA;
      status[ST_OLB]   = olB;
      status[ST_UV]    = uv;
      status[ST_STALL] = stall;
   end

   assign wbReq = wb_cyc_i & wb_stb_i & ~cur_ff.ack;

   always_comb begin
      nxt_cur       = cur_ff;
      nxt_cur.syncA = rawIn;
      nxt_cur.syncB = cur_ff.syncA;

      // Temperature protection with hysteresis down to the warning level.
      nxt_cur.otpw = (temp > warnLvl);
      if (temp >= shutLvl) begin
         nxt_cur.ot = 1'b1;
      end else if (temp < warnLvl) begin
         nxt_cur.ot = 1'b0;
      end

      // Marker output: microstep zero or a toggle per step.
      nxt_cur.stepPrev = step;
      if (cur_ff.conf[CONF_MARK_STP]) begin
         if (step && !cur_ff.stepPrev) begin
            nxt_cur.marker = ~cur_ff.marker;
         end
      end else begin
         nxt_cur.marker = atZero;
      end

      // Sticky events on rising status bits; a read clears, a set wins.
      nxt_cur.statPrev = status;
      nxt_cur.ack      = wbReq;
      nxt_cur.rdata    = 32'h0000_0000;
      if (wbReq) begin
         if (wb_we_i) begin
            if (wb_adr_i == REG_CONF && wb_sel_i[0]) begin
               nxt_cur.conf = wb_dat_i[CONF_W-1:0];
            end
            if (wb_adr_i == REG_IRQMSK) begin
               if (wb_sel_i[0]) begin
                  nxt_cur.irqMask[7:0] = wb_dat_i[7:0];
               end
               if (wb_sel_i[1]) begin
                  nxt_cur.irqMask[9:8] = wb_dat_i[9:8];
               end
            end
         end else begin
            case (wb_adr_i)
               REG_CONF:   nxt_cur.rdata = {25'h0, cur_ff.conf};
               REG_STATUS: nxt_cur.rdata = {22'h0, status};
               REG_IRQST: begin
                  nxt_cur.rdata = {22'h0, cur_ff.irqSt};
                  nxt_cur.irqSt = '0;
               end
               REG_IRQMSK: nxt_cur.rdata = {22'h0, cur_ff.irqMask};
               default:    nxt_cur.rdata = 32'h0000_0000;
            endcase
         end
      end
      nxt_cur.irqSt = nxt_cur.irqSt | (status & ~cur_ff.statPrev);
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         cur_ff         <= '0;
         cur_ff.conf    <= CONF_RESET;
         cur_ff.irqMask <= IRQ_MASK_RESET;
      end else begin
         cur_ff <= nxt_cur;
      end
   end

   // Open-load flags deliberately take no part in the enables.
   assign bridgeAEnable = drvEn & ~cur_ff.ot & ~offA;
   assign bridgeBEnable = drvEn & ~cur_ff.ot & ~offB;
   assign faultOutputPin = cur_ff.ot | offA | offB | uv
                           | (stall & cur_ff.conf[CONF_STALL_EN]);
   assign markerPin = cur_ff.marker;
   assign irq       = |(cur_ff.irqSt & cur_ff.irqMask);
   assign wb_ack_o  = cur_ff.ack;
   assign wb_dat_o  = cur_ff.rdata;
endmodule
`default_nettype wire

/* dv/mfd_fault_fault_output_pin_assertions.sv */
// Checker for the fault diagnostics top, bound to every instance.
// Assumes all sensor pins change only just after sys_clk edges.
`timescale 1ns/10ps
`default_nettype none
module mfd_fault_fault_output_pin_checker
   import mfd_pkg::*;
(
   input wire logic        sys_clk,
   input wire logic        rst,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [7:0]  wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic        wb_ack_o,
   input wire logic [7:0]  dieTemp,
   input wire logic        shortGndA,
   input wire logic        shortGndB,
   input wire logic        shortSupA,
   input wire logic        shortSupB,
   input wire logic        coilLowA,
   input wire logic        stepDone,
   input wire logic        stepAtZero,
   input wire logic        bridgeAEnable,
   input wire logic        bridgeBEnable,
   input wire logic        faultOutputPin,
   input wire logic        markerPin
);
   logic [6:0] confFf;
   logic [7:0] coolFf, cntAFf, cntBFf;
   logic       stepFf, en, cool, calm, rise, mode;
   // Counts saturate so a long run cannot wrap them into a calm state.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         confFf <= CONF_RESET;
         coolFf <= 8'h00;
         cntAFf <= 8'h00;
         cntBFf <= 8'h00;
         stepFf <= 1'b0;
      end else begin
         if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o &&
             wb_adr_i == REG_CONF && wb_sel_i[0]) begin
            confFf <= wb_dat_i[6:0];
         end
         coolFf <= (dieTemp >= TEMP_120) ? 8'h00 :
                   coolFf + {7'h00, coolFf != 8'hff};
         // A disabled driver forgets its tries, so the counts restart too.
         if (!en) begin
            cntAFf <= 8'h00;
            cntBFf <= 8'h00;
         end else begin
            cntAFf <= cntAFf +
                      {7'h00, (shortGndA || shortSupA) && &cntAFf == 0};
            cntBFf <= cntBFf +
                      {7'h00, (shortGndB || shortSupB) && &cntBFf == 0};
         end
         stepFf <= stepDone;
      end
   end
   assign en   = confFf[CONF_DRV_EN];
   assign cool = coolFf >= 8'h08;
   assign calm = en && cool && cntAFf < 8'h0a;
   assign rise = stepDone && !stepFf;
   assign mode = confFf[CONF_MARK_STP];
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   a_hot_bridges_off: assert property (
      (dieTemp >= TEMP_157) [*4] |-> !bridgeAEnable && !bridgeBEnable)
      else $error("Bridge on while the die is hot.");
   a_short_a_three: assert property (
      en && cool && !bridgeAEnable && $past(!bridgeAEnable) |->
      cntAFf >= 8'h1e)
      else $error("Bridge A latched off before three short tries.");
   a_short_b_own: assert property (
      en && cool && !bridgeBEnable && $past(!bridgeBEnable) |->
      cntBFf >= 8'h1e)
      else $error("Bridge B latched off without its own short.");
   a_latch_stays_off: assert property (
      en && cool && !bridgeAEnable && $past(!bridgeAEnable) |=>
      !bridgeAEnable || !en)
      else $error("Shorted bridge came back without restart.");
   a_openload_no_act: assert property (
      calm && $past(calm) && coilLowA |-> bridgeAEnable)
      else $error("Bridge A off for an open load.");
   a_fault_on_short: assert property (
      en && cool && !bridgeAEnable |-> faultOutputPin)
      else $error("Fault pin low while a bridge is latched off.");
   a_marker_follows: assert property (
      (!mode && $stable(stepAtZero)) [*4] |-> markerPin == stepAtZero)
      else $error("Marker does not show the zero position.");
   a_marker_toggles: assert property (
      mode && $past(mode, 4) && $changed(markerPin) |->
      $past(rise, 2) || $past(rise, 3) || $past(rise, 4))
      else $error("Marker toggled without a step.");
   c_short_off: cover property ($fell(bridgeAEnable) && cool);
   c_step_toggle: cover property (mode && $changed(markerPin));
   c_hot: cover property ((dieTemp >= TEMP_157) [*4]);
endmodule
bind mfd_fault_fault_output_pin mfd_fault_fault_output_pin_checker u_mfd_fault_fault_output_pin_checker (
   .sys_clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
   .wb_dat_i, .wb_ack_o, .dieTemp, .shortGndA, .shortGndB, .shortSupA,
   .shortSupB, .coilLowA, .stepDone, .stepAtZero, .bridgeAEnable,
   .bridgeBEnable, .faultOutputPin, .markerPin
);
`default_nettype wire

/* dv/mfd_host_model.sv */
// Host controller model: a classic Wishbone master with register tasks.
// Assumes a slave that acks each request; the bench timeout ends a hang.
`timescale 1ns/10ps
`default_nettype none
module mfd_host_model
   import mfd_pkg::*;
(
   input  wire logic        sys_clk,
   output logic             cyc,
   output logic             stb,
   output logic             we,
   output logic [7:0]       adr,
   output logic [3:0]       sel,
   output logic [31:0]      datW,
   input  wire logic [31:0] datR,
   input  wire logic        ack
);
   initial begin
      {cyc, stb, we, adr, sel, datW} = '0;
   end
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [3:0] s, input logic [31:0] dw,
                       output logic [31:0] q);
      @(posedge sys_clk);
      {cyc, stb, we, adr, sel, datW} <= {1'b1, 1'b1, w, a, s, dw};
      do @(posedge sys_clk); while (ack !== 1'b1);
      q = datR;
      {cyc, stb, we} <= 3'h0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [3:0] s,
                     input logic [31:0] dw);
      logic [31:0] q;
      xfer(1'b1, a, s, dw, q);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      xfer(1'b0, a, 4'hf, 32'h0, q);
   endtask
   // A latched bridge only returns after the driver goes off and on.
   task automatic restart();
      wr(REG_CONF, 4'h1, 32'h0);
      wr(REG_CONF, 4'h1, 32'h1);
   endtask
endmodule
`default_nettype wire

/* dv/test_mfd_fault_fault_output_pin.sv */
// Self-checking bench of the fault diagnostics block.
// Assumes the host model as bus master and sensor pins driven from here.
`timescale 1ns/10ps
`default_nettype none
module test_mfd_fault_fault_output_pin;
   import mfd_pkg::*;
   typedef struct packed {
      logic [7:0] conf; logic [2:0] otp; logic [7:0] temp; logic [1:0] st;
   } mfd_row_type;
   mfd_row_type rows [20] = '{
      '{8'h01,3'h0,8'h8e,2'h2}, '{8'h01,3'h0,8'h8f,2'h3},
      '{8'h01,3'h0,8'h79,2'h3}, '{8'h01,3'h0,8'h77,2'h0},
      '{8'h03,3'h0,8'h95,2'h2}, '{8'h03,3'h0,8'h96,2'h3},
      '{8'h03,3'h0,8'h77,2'h0}, '{8'h23,3'h0,8'h90,2'h2},
      '{8'h23,3'h0,8'h96,2'h3}, '{8'h23,3'h0,8'h8e,2'h0},
      '{8'h05,3'h0,8'h9c,2'h2}, '{8'h05,3'h0,8'h9d,2'h3},
      '{8'h05,3'h0,8'h8f,2'h1}, '{8'h05,3'h0,8'h77,2'h0},
      '{8'h41,3'h2,8'h96,2'h3}, '{8'h41,3'h2,8'h77,2'h0},
      '{8'h41,3'h3,8'h90,2'h2}, '{8'h41,3'h3,8'h77,2'h0},
      '{8'h41,3'h4,8'h8f,2'h3}, '{8'h41,3'h4,8'h77,2'h0}};
   logic        sys_clk, rst, cyc, stb, we, ack, irq, brA, brB, fault, mark;
   logic        uv, olA, olB, stall, step, atZero, pw, prevMark;
   logic [1:0]  otpSel;
   logic [3:0]  sel, sh;
   logic [7:0]  adr, dieTemp;
   logic [31:0] datW, datR, d;
   int          failures, checked, toggles, m0;
   mfd_fault_fault_output_pin u_mfd_fault_fault_output_pin (
      .sys_clk, .rst, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datW), .wb_dat_o(datR),
      .wb_ack_o(ack), .irq, .dieTemp, .shortGndA(sh[0]), .shortGndB(sh[1]),
      .shortSupA(sh[2]), .shortSupB(sh[3]), .underVoltage(uv),
      .coilLowA(olA), .coilLowB(olB), .stallDetect(stall), .stepDone(step),
      .stepAtZero(atZero), .otpTempSel(otpSel), .otpPw143(pw),
      .bridgeAEnable(brA), .bridgeBEnable(brB), .faultOutputPin(fault),
      .markerPin(mark));
   mfd_host_model u_mfd_host_model (
      .sys_clk, .cyc, .stb, .we, .adr, .sel, .datW, .datR, .ack);
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict();
      $display("failures=%0d checked=%0d", failures, checked);
      if (failures == 0 && checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic wait_n(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   task automatic steps(input int n);
      repeat (n) begin
         step <= 1'b1;
         wait_n(4);
         step <= 1'b0;
         wait_n(4);
      end
   endtask
   // Each pulse outlasts the qualify time, so each one is a single try.
   task automatic shorts(input logic [3:0] which, input int n);
      repeat (n) begin
         sh <= which;
         wait_n(12);
         sh <= 4'h0;
         wait_n(5);
      end
   endtask
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      if (mark !== prevMark) toggles++;
      prevMark <= mark;
   end
   initial begin
      wait_n(30000);
      failures++;
      print_verdict();
   end
   initial begin
      {rst, uv, olA, olB, stall, step, atZero, pw, otpSel, sh} = 14'h2000;
      dieTemp = 8'h40;
      wait_n(10);
      rst <= 1'b0;
      @(posedge sys_clk);
      check({brA, brB, fault, mark, irq, ack}, 6'h00);
      u_mfd_host_model.wr(8'h10, 4'hf, 32'hffffffff);
      u_mfd_host_model.rd(8'h10, d);
      check(d, 32'h0);
      u_mfd_host_model.rd(REG_CONF, d);
      check(d, {25'h0, CONF_RESET});
      foreach (rows[i]) begin
         @(posedge sys_clk);
         dieTemp <= rows[i].temp;
         {otpSel, pw} <= rows[i].otp;
         u_mfd_host_model.wr(REG_CONF, 4'h1, {24'h0, rows[i].conf});
         wait_n(8);
         u_mfd_host_model.rd(REG_STATUS, d);
         check(d[1:0], rows[i].st);
         check({brA, brB}, {2{~rows[i].st[0]}});
      end
      olA <= 1'b1;
      steps(16);
      u_mfd_host_model.rd(REG_STATUS, d);
      check(d[7:6], 2'h1);
      check({brA, brB}, 2'h3);
      atZero <= 1'b1;
      wait_n(6);
      check(mark, 1'b1);
      atZero <= 1'b0;
      u_mfd_host_model.wr(REG_CONF, 4'h1, 32'h11);
      wait_n(6);
      m0 = toggles;
      steps(5);
      check(toggles - m0, 32'h5);
      olA <= 1'b0;
      stall <= 1'b1;
      u_mfd_host_model.wr(REG_CONF, 4'h1, 32'h09);
      wait_n(6);
      check(fault, 1'b1);
      u_mfd_host_model.rd(REG_STATUS, d);
      check(d[9], 1'b1);
      u_mfd_host_model.wr(REG_CONF, 4'h1, 32'h01);
      wait_n(6);
      check(fault, 1'b0);
      stall <= 1'b0;
      u_mfd_host_model.wr(REG_CONF, 4'h1, 32'h0);
      wait_n(6);
      u_mfd_host_model.rd(REG_IRQST, d);
      u_mfd_host_model.wr(REG_IRQMSK, 4'h3, 32'h100);
      olB <= 1'b1;
      wait_n(6);
      check(irq, 1'b0);
      uv <= 1'b1;
      wait_n(6);
      check(irq, 1'b1);
      u_mfd_host_model.rd(REG_STATUS, d);
      check({d[8], d[7]}, 2'h3);
      u_mfd_host_model.rd(REG_IRQST, d);
      check(d[8:7], 2'h3);
      @(posedge sys_clk);
      check(irq, 1'b0);
      {uv, olB} <= 2'h0;
      u_mfd_host_model.wr(REG_CONF, 4'h1, 32'h1);
      shorts(4'h1, 2);
      check({brA, brB}, 2'h3);
      shorts(4'h1, 1);
      check({brA, brB}, 2'h1);
      u_mfd_host_model.rd(REG_STATUS, d);
      check(d[5:2], 4'h1);
      wait_n(20);
      check({brA, brB, fault}, 3'h3);
      u_mfd_host_model.restart();
      @(posedge sys_clk);
      check({brA, brB}, 2'h3);
      shorts(4'h8, 3);
      check({brA, brB}, 2'h2);
      u_mfd_host_model.rd(REG_STATUS, d);
      check(d[5:2], 4'h8);
      u_mfd_host_model.restart();
      u_mfd_host_model.rd(REG_STATUS, d);
      check({d[5:2], brA, brB}, 6'h03);
      // A reset in mid-run must drop the mask and the enables again.
      u_mfd_host_model.wr(REG_IRQMSK, 4'h3, 32'h3ff);
      rst <= 1'b1;
      wait_n(2);
      rst <= 1'b0;
      @(posedge sys_clk);
      check({brA, brB, fault, mark, irq, ack}, 6'h00);
      u_mfd_host_model.rd(REG_IRQMSK, d);
      check(d, {22'h0, IRQ_MASK_RESET});
      u_mfd_host_model.rd(REG_CONF, d);
      check(d, {25'h0, CONF_RESET});
      print_verdict();
   end
endmodule
`default_nettype wire
